// >>> inc/acs_cfg.svh
// Constants for the channel input and setup configuration bank
`ifndef ACS_CFG_SVH
`define ACS_CFG_SVH

// ----------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define ACS_CH_IDX_FIRST 8'h10
`define ACS_CH_IDX_LAST 8'h1F
`define ACS_SETUP_IDX_FIRST 8'h20
`define ACS_SETUP_IDX_LAST 8'h27

// ----------------------------------------------------------------
// Channel register fields
// ----------------------------------------------------------------
`define ACS_CH_SEL_MSB 9
`define ACS_CH_SEL_LSB 0
`define ACS_CH_SETUP_MSB 14
`define ACS_CH_SETUP_LSB 12
`define ACS_CH_SEL_RST 10'h001
`define ACS_CH_SETUP_RST 3'h0

// ----------------------------------------------------------------
// Setup register fields
// ----------------------------------------------------------------
`define ACS_SU_CODING_BIT 12
`define ACS_SU_REFBUFP_BIT 11
`define ACS_SU_REFBUFN_BIT 10
`define ACS_SU_INBUF_MSB 9
`define ACS_SU_INBUF_LSB 8
`define ACS_SU_REFSEL_MSB 5
`define ACS_SU_REFSEL_LSB 4
`define ACS_SU_RST 16'h1000
`define ACS_SU_WMASK 16'h1F30
`define ACS_INBUF_OFF 2'b00
`define ACS_INBUF_ON 2'b11

// ----------------------------------------------------------------
// Input pair select code fields
// ----------------------------------------------------------------
`define ACS_POS_MSB 9
`define ACS_POS_LSB 5
`define ACS_NEG_MSB 4
`define ACS_NEG_LSB 0
`define ACS_PIN_COMMON 5'h10
`define ACS_PIN_LL_COMMON 5'h0F
`define ACS_PIN_HV_LAST 5'h0A
`define ACS_PIN_LL_FIRST 5'h0B
`define ACS_PIN_LL_LAST 5'h0E
`define ACS_CODE_TEMP 10'h232
`define ACS_CODE_REF 10'h2B6

`endif

// >>> inc/acs_pkg.sv
// Types shared by the channel input and setup configuration bank
package acs_pkg;

  typedef enum logic [2:0] {
    ACS_KIND_BAD = 3'h0,
    ACS_KIND_HV_DIFF = 3'h1,
    ACS_KIND_HV_COMMON = 3'h2,
    ACS_KIND_LL_DIFF = 3'h3,
    ACS_KIND_LL_PSEUDO = 3'h4,
    ACS_KIND_TEMP = 3'h5,
    ACS_KIND_REF = 3'h6
  } acs_kind_t;

  typedef enum logic [1:0] {
    ACS_REF_EXTERNAL = 2'h0,
    ACS_REF_RSVD = 2'h1,
    ACS_REF_INTERNAL = 2'h2,
    ACS_REF_SUPPLY = 2'h3
  } acs_ref_t;

endpackage

// >>> rtl/acs_input_decode.sv
// Decoder from an input pair select code to a connection kind
`timescale 1ns/1ps
`include "acs_cfg.svh"

module acs_input_decode (
  input wire logic [9:0] code,
  output acs_pkg::acs_kind_t kind,
  output logic [4:0] pos_pin,
  output logic [4:0] neg_pin
);
  import acs_pkg::*;

  logic [4:0] p;
  logic [4:0] n;
  logic [4:0] q;
  logic [4:0] r;

  assign p = code[`ACS_POS_MSB:`ACS_POS_LSB];
  assign n = code[`ACS_NEG_MSB:`ACS_NEG_LSB];
  // Offsets into the low-level group; pairs differ only in bit 0
  assign q = p - `ACS_PIN_LL_FIRST;
  assign r = n - `ACS_PIN_LL_FIRST;
  assign pos_pin = p;
  assign neg_pin = n;

  // ----------------------------------------------------------------
  // Legal codes only; anything else is reported as bad
  // ----------------------------------------------------------------
  always_comb begin
    kind = ACS_KIND_BAD;
    if (code == `ACS_CODE_TEMP) begin
      kind = ACS_KIND_TEMP;
    end else if (code == `ACS_CODE_REF) begin
      kind = ACS_KIND_REF;
    end else if (p <= `ACS_PIN_HV_LAST && n == `ACS_PIN_COMMON) begin
      kind = ACS_KIND_HV_COMMON;
    end else if (p < `ACS_PIN_HV_LAST && n == {p[4:1], ~p[0]}) begin
      kind = ACS_KIND_HV_DIFF;
    end else if (p >= `ACS_PIN_LL_FIRST && p <= `ACS_PIN_LL_LAST) begin
      // Low-level pairs: 11/12 and 13/14 either way round, or vs 15
      if (n == `ACS_PIN_LL_COMMON) begin
        kind = ACS_KIND_LL_PSEUDO;
      end else if (n >= `ACS_PIN_LL_FIRST && n <= `ACS_PIN_LL_LAST
                   && (q ^ r) == 5'h01) begin
        kind = ACS_KIND_LL_DIFF;
      end
    end
  end

endmodule

// >>> rtl/acs_setup_regs.sv
// Channel input selection and setup configuration register bank
//
// Summary of operation
// - Channel register bits 9:0 hold input pair select, reset 1.
// - Input select codes decode to pairs, common input, temp and reference.
// - Code 0101010000 connects high-voltage input 10 against common input.
// - Low-level inputs support differential and pseudo-differential pairs.
// - Eight 16-bit setup registers at indices 0x20..0x27, reset 0x1000.
// - Setup bit 12 picks coding: 0 unipolar, 1 bipolar; reset 1.
// - Setup bit 11 enables the positive reference buffer; reset 0.
// - Setup bit 10 enables the negative reference buffer; reset 0.
// - Setup bits 9:8: 00 off, 11 on; 01 and 10 never written.
// - Setup bits 5:4 pick reference: external, internal, or supply.
// - Setup reserved bits read zero; software writes zeros there.
// - Channel register bits 14:12 name the setup used by that channel.
`timescale 1ns/1ps
`include "acs_cfg.svh"

module acs_setup_regs #(
  parameter int NUM_CH = 16,
  parameter int NUM_SETUP = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [3:0] active_channel,
  output logic [9:0] channel_input_pair_select,
  output acs_pkg::acs_kind_t active_input_kind,
  output logic [4:0] active_pos_pin,
  output logic [4:0] active_neg_pin,
  output logic [2:0] channel_setup_index,
  output logic output_coding_polarity,
  output logic pos_reference_buffer_en,
  output logic neg_reference_buffer_en,
  output logic analog_input_buffer_en,
  output acs_pkg::acs_ref_t reference_source_select
);
  import acs_pkg::*;

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [9:0] ch_sel_ff [NUM_CH];
  logic [2:0] ch_setup_ff [NUM_CH];
  logic [15:0] setup_config_ff [NUM_SETUP];

  logic [31:0] prdata_ff;
  logic pready_ff;
  logic pslverr_ff;

  logic [9:0] act_sel_ff;
  acs_kind_t act_kind_ff;
  logic [4:0] act_pos_ff;
  logic [4:0] act_neg_ff;
  logic [2:0] act_setup_ff;
  logic coding_ff;
  logic refbuf_p_ff;
  logic refbuf_n_ff;
  logic inbuf_ff;
  acs_ref_t ref_sel_ff;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  logic [7:0] reg_idx;
  logic addr_aligned;
  logic hit_ch;
  logic hit_setup;
  logic [3:0] ch_idx;
  logic [2:0] su_idx;

  function automatic logic in_range(input logic [7:0] idx,
                                    input logic [7:0] lo,
                                    input logic [7:0] hi);
    in_range = (idx >= lo) && (idx <= hi);
  endfunction

  // Reserved bits are forced to zero on every path into storage
  function automatic logic [15:0] su_mask(input logic [15:0] v);
    su_mask = v & `ACS_SU_WMASK;
  endfunction

  assign reg_idx = paddr[9:2];
  assign addr_aligned = (paddr[1:0] == 2'b00) && (paddr[11:10] == 2'b00);
  assign ch_idx = reg_idx[3:0];
  assign su_idx = reg_idx[2:0];
  assign hit_ch = addr_aligned && in_range(reg_idx, `ACS_CH_IDX_FIRST,
                                           `ACS_CH_IDX_LAST)
                  && (32'(ch_idx) < NUM_CH);
  assign hit_setup = addr_aligned && in_range(reg_idx,
                                              `ACS_SETUP_IDX_FIRST,
                                              `ACS_SETUP_IDX_LAST)
                     && (32'(su_idx) < NUM_SETUP);

  // ----------------------------------------------------------------
  // Write data merge and reserved-code check
  // ----------------------------------------------------------------
  logic [15:0] wr_ch_word;
  logic [15:0] wr_su_word;
  logic [15:0] old_ch_word;
  logic [15:0] strb_mask;
  logic bad_inbuf;
  logic acc_err;
  logic [31:0] rd_word;

  always_comb begin
    old_ch_word = 16'h0000;
    old_ch_word[`ACS_CH_SEL_MSB:`ACS_CH_SEL_LSB] = ch_sel_ff[ch_idx];
    old_ch_word[`ACS_CH_SETUP_MSB:`ACS_CH_SETUP_LSB] = ch_setup_ff[ch_idx];
  end

  assign strb_mask = {{8{pstrb[1]}}, {8{pstrb[0]}}};
  assign wr_ch_word = (pwdata[15:0] & strb_mask) | (old_ch_word & ~strb_mask);
  assign wr_su_word = su_mask((pwdata[15:0] & strb_mask)
                              | (setup_config_ff[su_idx] & ~strb_mask));
  // Half-set buffer codes would leave the front end in an undefined state
  assign bad_inbuf = hit_setup && pwrite
                     && (wr_su_word[`ACS_SU_INBUF_MSB]
                         != wr_su_word[`ACS_SU_INBUF_LSB]);
  assign acc_err = !(hit_ch || hit_setup) || bad_inbuf;

  always_comb begin
    rd_word = 32'h0000_0000;
    if (hit_ch) begin
      rd_word[15:0] = old_ch_word;
    end else if (hit_setup) begin
      rd_word[15:0] = su_mask(setup_config_ff[su_idx]);
    end
  end

  // ----------------------------------------------------------------
  // APB slave: one wait state, answer registered
  // ----------------------------------------------------------------
  logic access_first;
  logic commit;

  assign access_first = psel && penable && !pready_ff;
  assign commit = psel && penable && pready_ff;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff <= 1'b0;
    end else if (clk_en) begin
      pready_ff <= access_first;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff <= 32'h0000_0000;
      pslverr_ff <= 1'b0;
    end else if (clk_en) begin
      if (access_first) begin
        prdata_ff <= pwrite ? 32'h0000_0000 : rd_word;
        pslverr_ff <= acc_err;
      end else if (commit) begin
        pslverr_ff <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Channel registers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NUM_CH; i++) begin
        ch_sel_ff[i] <= `ACS_CH_SEL_RST;
        ch_setup_ff[i] <= `ACS_CH_SETUP_RST;
      end
    end else if (clk_en && commit && pwrite && hit_ch) begin
      ch_sel_ff[ch_idx] <= wr_ch_word[`ACS_CH_SEL_MSB:`ACS_CH_SEL_LSB];
      ch_setup_ff[ch_idx] <=
        wr_ch_word[`ACS_CH_SETUP_MSB:`ACS_CH_SETUP_LSB];
    end
  end

  // ----------------------------------------------------------------
  // Setup registers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NUM_SETUP; i++) begin
        setup_config_ff[i] <= `ACS_SU_RST;
      end
    end else if (clk_en && commit && pwrite && hit_setup && !bad_inbuf) begin
      setup_config_ff[su_idx] <= wr_su_word;
    end
  end

  // ----------------------------------------------------------------
  // Active channel view for the converter
  // ----------------------------------------------------------------
  acs_kind_t dec_kind;
  logic [4:0] dec_pos;
  logic [4:0] dec_neg;
  logic [9:0] cur_sel;
  logic [2:0] cur_setup;
  logic [15:0] cur_su;

  assign cur_sel = ch_sel_ff[active_channel];
  assign cur_setup = ch_setup_ff[active_channel];
  assign cur_su = setup_config_ff[cur_setup];

  acs_input_decode u_decode (
    .code(cur_sel),
    .kind(dec_kind),
    .pos_pin(dec_pos),
    .neg_pin(dec_neg)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      act_sel_ff <= `ACS_CH_SEL_RST;
      act_kind_ff <= ACS_KIND_HV_DIFF;
      act_pos_ff <= 5'(`ACS_CH_SEL_RST >> `ACS_POS_LSB);
      act_neg_ff <= 5'(`ACS_CH_SEL_RST);
      act_setup_ff <= `ACS_CH_SETUP_RST;
    end else if (clk_en) begin
      act_sel_ff <= cur_sel;
      act_kind_ff <= dec_kind;
      act_pos_ff <= dec_pos;
      act_neg_ff <= dec_neg;
      act_setup_ff <= cur_setup;
    end
  end

  // Setup fields of the setup named by the active channel
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      coding_ff <= 1'(`ACS_SU_RST >> `ACS_SU_CODING_BIT);
      refbuf_p_ff <= 1'b0;
      refbuf_n_ff <= 1'b0;
      inbuf_ff <= 1'b0;
      ref_sel_ff <= ACS_REF_EXTERNAL;
    end else if (clk_en) begin
      coding_ff <= cur_su[`ACS_SU_CODING_BIT];
      refbuf_p_ff <= cur_su[`ACS_SU_REFBUFP_BIT];
      refbuf_n_ff <= cur_su[`ACS_SU_REFBUFN_BIT];
      inbuf_ff <= (cur_su[`ACS_SU_INBUF_MSB:`ACS_SU_INBUF_LSB]
                   == `ACS_INBUF_ON);
      // Internal code only routes the reference; power is elsewhere
      ref_sel_ff <= acs_ref_t'(
        cur_su[`ACS_SU_REFSEL_MSB:`ACS_SU_REFSEL_LSB]);
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign channel_input_pair_select = act_sel_ff;
  assign active_input_kind = act_kind_ff;
  assign active_pos_pin = act_pos_ff;
  assign active_neg_pin = act_neg_ff;
  assign channel_setup_index = act_setup_ff;
  assign output_coding_polarity = coding_ff;
  assign pos_reference_buffer_en = refbuf_p_ff;
  assign neg_reference_buffer_en = refbuf_n_ff;
  assign analog_input_buffer_en = inbuf_ff;
  assign reference_source_select = ref_sel_ff;

endmodule

// >>> verif/acs_setup_regs_properties.sv
// Bus timing and read-value checks for the setup configuration bank
`timescale 1ns/1ps
module acs_setup_regs_properties (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [9:0] channel_input_pair_select,
  input wire logic [2:0] channel_setup_index,
  input wire logic output_coding_polarity,
  input acs_pkg::acs_ref_t reference_source_select
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire [7:0] idx = paddr[9:2];
  wire al = paddr[1:0] == 2'b00 && paddr[11:10] == 2'b00;
  wire su = al && idx >= 8'h20 && idx <= 8'h27;
  wire ch = al && idx >= 8'h10 && idx <= 8'h1F;
  wire fin = psel && penable && pready;
  wire [1:0] ib = pwdata[9:8];
  a_one_wait: assert property (psel && penable && !pready && clk_en |=> pready) else $error("pready late");
  a_ready_pulse: assert property (pready && clk_en |=> !pready) else $error("pready held");
  a_err_at_end: assert property (pslverr |-> pready) else $error("stray pslverr");
  a_upper_zero: assert property (pready |-> prdata[31:16] == 16'h0000) else $error("upper data set");
  a_setup_rsvd: assert property (fin && !pwrite && su |-> (prdata[15:0] & 16'hE0CF) == 16'h0000) else $error("setup reserved set");
  a_ch_rsvd: assert property (fin && !pwrite && ch |-> prdata[15:10] == {1'b0, prdata[14:12], 2'b00}) else $error("channel reserved set");
  a_bad_inbuf: assert property (fin && pwrite && su && pstrb[1] && ^ib |-> pslverr) else $error("reserved buffer code taken");
  a_unmapped_err: assert property (fin && !(su || ch) |-> pslverr && prdata == 32'h0) else $error("unmapped answered");
  a_reset_view: assert property ($rose(presetn) |-> channel_input_pair_select == 10'h001 && channel_setup_index == 3'h0 && output_coding_polarity && reference_source_select == acs_pkg::ACS_REF_EXTERNAL) else $error("view not at reset");
endmodule

bind acs_setup_regs acs_setup_regs_properties u_props (.pclk(pclk),
  .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
  .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .channel_input_pair_select(channel_input_pair_select),
  .channel_setup_index(channel_setup_index),
  .output_coding_polarity(output_coding_polarity),
  .reference_source_select(reference_source_select));

// >>> verif/acs_setup_regs_tb.sv
// Self-checking bench for the setup configuration bank
`timescale 1ns/1ps
module acs_setup_regs_tb;
  import acs_pkg::*;
  logic pclk = 0, presetn = 0, clk_en = 1, psel = 0, penable = 0;
  logic pwrite = 0, pready, pslverr, ocp, pbe, nbe, abe, er;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd, d;
  logic [3:0] pstrb = 0, active_channel = 0;
  logic [9:0] sel, c;
  logic [4:0] pp, np;
  logic [2:0] sidx;
  acs_kind_t kind;
  acs_ref_t rsel;
  int error_cnt = 0, checked = 0, cyc = 0;
  logic [15:0] ch_m [16], su_m [8];
  logic [9:0] codes [31] = '{10'h001, 10'h010, 10'h020, 10'h030, 10'h043,
    10'h050, 10'h062, 10'h070, 10'h085, 10'h090, 10'h0A4, 10'h0B0, 10'h0C7,
    10'h0D0, 10'h0E6, 10'h0F0, 10'h109, 10'h110, 10'h128, 10'h130, 10'h150,
    10'h16C, 10'h18B, 10'h1AE, 10'h1CD, 10'h16F, 10'h18F, 10'h1AF, 10'h1CF,
    10'h232, 10'h2B6};
  acs_setup_regs u_acs_setup_regs (.pclk(pclk), .presetn(presetn),
    .clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .active_channel(active_channel),
    .channel_input_pair_select(sel), .active_input_kind(kind),
    .active_pos_pin(pp), .active_neg_pin(np), .channel_setup_index(sidx),
    .output_coding_polarity(ocp), .pos_reference_buffer_en(pbe),
    .neg_reference_buffer_en(nbe), .analog_input_buffer_en(abe),
    .reference_source_select(rsel));
  initial forever #2 pclk = ~pclk;
  always @(posedge pclk) if (++cyc > 8000) begin
    error_cnt++;
    wrap_up();
  end
  // ----------------------------------------------------------------
  // Bus tasks and reference model
  // ----------------------------------------------------------------
  task automatic wrap_up();
    if (error_cnt == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] dd,
                     input logic [3:0] s);
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= dd;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  // Untouched lanes keep the stored bits
  function automatic logic [15:0] mrg(logic [15:0] o, logic [3:0] s,
                                      logic [15:0] m);
    logic [15:0] l = {{8{s[1]}}, {8{s[0]}}};
    return ((o & ~l) | (d[15:0] & l)) & m;
  endfunction
  task automatic acc(input logic w, input logic [7:0] i, input logic [3:0] s);
    logic [15:0] nv;
    logic e = !(i inside {[8'h10:8'h1F], [8'h20:8'h27]});
    logic u = i >= 8'h20;
    nv = u ? mrg(su_m[i[2:0]], s, 16'h1F30) : mrg(ch_m[i[3:0]], s, 16'h73FF);
    if (w && u && !e) e = ^nv[9:8];
    apb(w, {2'b00, i, 2'b00}, d, s);
    chk(er, e);
    if (!w) chk(rd, e ? 0 : {16'h0, u ? su_m[i[2:0]] : ch_m[i[3:0]]});
    else if (!e && u) su_m[i[2:0]] = nv;
    else if (!e) ch_m[i[3:0]] = nv;
  endtask
  function automatic acs_kind_t kind_of(logic [9:0] k);
    logic [4:0] p = k[9:5], n = k[4:0], q = p - 5'd11, r = n - 5'd11;
    if (k == 10'h232) return ACS_KIND_TEMP;
    if (k == 10'h2B6) return ACS_KIND_REF;
    if (n == 5'd16 && p <= 5'd10) return ACS_KIND_HV_COMMON;
    if (p <= 5'd9 && n <= 5'd9 && (p ^ n) == 5'd1) return ACS_KIND_HV_DIFF;
    if (q <= 5'd3 && n == 5'd15) return ACS_KIND_LL_PSEUDO;
    if (q <= 5'd3 && r <= 5'd3 && (q ^ r) == 5'd1) return ACS_KIND_LL_DIFF;
    return ACS_KIND_BAD;
  endfunction
  task automatic view(input logic [3:0] h);
    logic [15:0] s;
    active_channel <= h;
    repeat (2) @(posedge pclk);
    s = su_m[ch_m[h][14:12]];
    chk(sel, ch_m[h][9:0]);
    chk(kind, kind_of(ch_m[h][9:0]));
    chk({pp, np}, ch_m[h][9:0]);
    chk(sidx, ch_m[h][14:12]);
    chk({ocp, pbe, nbe}, s[12:10]);
    chk(abe, s[9:8] == 2'b11);
    chk(rsel, s[5:4]);
  endtask
  task automatic do_reset();
    presetn <= 0;
    repeat (2) @(posedge pclk);
    presetn <= 1;
    foreach (ch_m[i]) ch_m[i] = 16'h0001;
    foreach (su_m[i]) su_m[i] = 16'h1000;
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(86));
    do_reset();
    d = 0;
    for (int i = 8'h0E; i < 8'h2A; i++) acc(0, i[7:0], 0);
    apb(0, 12'h082, 0, 0);
    chk(er, 1);
    apb(1, 12'hC80, 32'h1000, 4'hF);
    chk(er, 1);
    for (int i = 0; i < 40; i++) begin
      c = i < 31 ? codes[i] : 10'($urandom);
      d = {22'($urandom), c};
      acc(1, 8'h10 + 8'(i % 16), 4'($urandom));
      acc(0, 8'h10 + 8'(i % 16), 0);
      view(4'(i % 16));
    end
    for (int i = 0; i < 24; i++) begin
      d = $urandom;
      d[9:8] = {2{d[9]}};
      acc(1, 8'h20 + 8'(i % 8), 4'($urandom));
      acc(0, 8'h20 + 8'(i % 8), 0);
    end
    for (int j = 1; j < 3; j++) begin
      d = {22'h0, 2'(j), 8'h0};
      acc(1, 8'h23, 4'hF);
      acc(0, 8'h23, 0);
    end
    for (int h = 0; h < 16; h++) view(4'(h));
    // Frozen enable must hold the old view
    clk_en <= 0;
    active_channel <= 5;
    repeat (3) @(posedge pclk);
    chk(sel, ch_m[15][9:0]);
    clk_en <= 1;
    view(5);
    do_reset();
    view(5);
    acc(0, 8'h27, 0);
    wrap_up();
  end
endmodule
